// ==== opcode_decode_pkg.sv ====
// Package for the opcode decode and execute block.
// Assumes one core clock; program memory and internal RAM are outside.
package opcode_decode_pkg;

    // ************************************************************
    // Opcode patterns
    // ************************************************************
    localparam logic [4:0] CALL_LOW_PAT     = 5'h11;
    localparam logic [4:0] ADD_REG_PAT      = 5'h05;
    localparam logic [4:0] ADD_WITH_CARRY_REG_PAT     = 5'h07;
    localparam logic [6:0] ADD_IND_PAT      = 7'h13;
    localparam logic [6:0] ADD_WITH_CARRY_IND_PAT     = 7'h1B;
    localparam logic [7:0] ADD_DIR_OP       = 8'h25;
    localparam logic [7:0] ADD_IMM_OP       = 8'h24;
    localparam logic [7:0] ADD_WITH_CARRY_DIR_OP      = 8'h35;
    localparam logic [7:0] ADD_WITH_CARRY_IMM_OP      = 8'h34;
    localparam logic [7:0] CNT_DIR_OP       = 8'hD5;
    localparam logic [7:0] XRD_DATA_POINTER_OP      = 8'hE0;
    localparam logic [7:0] XWR_DATA_POINTER_OP      = 8'hF0;
    localparam logic [7:0] CLR_ACC_OP       = 8'hE4;
    localparam logic [7:0] CPL_ACC_OP       = 8'hF4;
    localparam logic [7:0] BIT_SET_C_OP        = 8'hD3;
    localparam logic [4:0] CNT_REG_PAT      = 5'h1B;
    localparam logic [4:0] MOV_A_REG_PAT    = 5'h1D;
    localparam logic [4:0] MOV_REG_A_PAT    = 5'h1F;

    // ************************************************************
    // Field positions and sizes, stack-pointer reset value
    // ************************************************************
    localparam int PAGE_LSB     = 11;
    localparam int OP_PAGE_LSB  = 5;
    localparam int BANK_SHIFT   = 3;
    localparam logic [7:0] SP_RESET = 8'h07;

    // ************************************************************
    // Carried types
    // ************************************************************
    typedef struct packed {
        logic cy;
        logic ac;
        logic ov;
    } flags_t;

    typedef struct packed {
        logic [7:0] sum;
        flags_t     flg;
    } add_res_t;

    typedef enum logic [3:0] {
        ST_FETCH, ST_BYTE2, ST_BYTE3, ST_OPND, ST_PTR, ST_PUSH_LO, ST_PUSH_HI,
        ST_CNT_WR, ST_XREAD
    } state_t;

    typedef struct packed {
        logic        we;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } ram_req_t;
endpackage

// ==== add_unit.sv ====
// Eight-bit adder with carry, auxiliary carry and signed excess.
// Assumes purely combinational use by the decoder.
`timescale 1ns/1ps
module add_unit (
    input  wire logic [7:0]                     a_i,
    input  wire logic [7:0]                     b_i,
    input  wire logic                           cin_i,
    output opcode_decode_pkg::add_res_t         res_o
);
    logic [4:0] low;
    logic [3:0] mid;
    logic [1:0] top;

    always_comb begin
        low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
        mid = {1'b0, a_i[6:4]} + {1'b0, b_i[6:4]} + {3'h0, low[4]};
        top = {1'b0, a_i[7]} + {1'b0, b_i[7]} + {1'b0, mid[3]};
        res_o.sum    = {top[0], mid[2:0], low[3:0]};
        res_o.flg.cy = top[1];
        res_o.flg.ac = low[4];
        res_o.flg.ov = top[1] ^ mid[3];
    end
endmodule

// ==== opcode_decode_add_call.sv ====
// Decode and execute for call, add and upper-map data moves.
// Assumes program memory and internal RAM answer in the same cycle.
// Function
// - Call adds two, pushes return low first
// - Target from PC top, opcode bits, byte
// - Call stays in current 2K block
// - Call recognised by low bits 1 0001
// - Call leaves all flags unchanged
// - Add sets carry and aux carry
// - Signed excess is carry6 xor carry7
// - Add with carry includes carry flag
// - Decode add register, direct, indirect, immediate
// - Decode add with carry source modes
// - D5 branch, E0/F0 external moves
`timescale 1ns/1ps
module opcode_decode_add_call #(
    parameter int PC_W = 16
) (
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_i,
    input  wire logic [7:0]              code_data_i,
    output logic      [PC_W-1:0]         code_addr_o,
    input  wire logic [7:0]              ram_rdata_i,
    output opcode_decode_pkg::ram_req_t  ram_req_o,
    input  wire logic [1:0]              bank_sel_i,
    input  wire logic [15:0]             data_pointer_i,
    input  wire logic [7:0]              xram_rdata_i,
    output logic      [15:0]             xram_addr_o,
    output logic      [7:0]              xram_wdata_o,
    output logic                         xram_we_o,
    output logic      [7:0]              acc_o,
    output logic      [7:0]              stack_pointer_o,
    output opcode_decode_pkg::flags_t    flags_o,
    output logic      [PC_W-1:0]         program_counter_o
);
    typedef struct packed {
        opcode_decode_pkg::state_t   st;
        logic [PC_W-1:0]             pc;
        logic [7:0]                  sp;
        logic [7:0]                  acc;
        opcode_decode_pkg::flags_t   flg;
        logic [7:0]                  op;
        logic [7:0]                  b2;
        logic [7:0]                  opnd;
        opcode_decode_pkg::ram_req_t ram;
        logic [15:0]                 xaddr;
        logic [7:0]                  xwd;
        logic                        xwe;
    } core_t;

    core_t cur_reg;
    core_t cur_next;
    opcode_decode_pkg::add_res_t add_res;
    logic [7:0] add_b;
    logic       add_cin;

    // ************************************************************
    // Helper decode
    // ************************************************************
    function automatic logic [7:0] reg_addr(input logic [1:0] bank, input logic [2:0] r);
        reg_addr = {3'h0, bank, r};
    endfunction

    function automatic logic is_call(input logic [7:0] op);
        is_call = op[4:0] == opcode_decode_pkg::CALL_LOW_PAT;
    endfunction

    function automatic logic is_add(input logic [7:0] op);
        is_add = op[7:3] == opcode_decode_pkg::ADD_REG_PAT
              || op[7:1] == opcode_decode_pkg::ADD_IND_PAT
              || op == opcode_decode_pkg::ADD_DIR_OP
              || op == opcode_decode_pkg::ADD_IMM_OP;
    endfunction

    function automatic logic is_add_with_carry(input logic [7:0] op);
        is_add_with_carry = op[7:3] == opcode_decode_pkg::ADD_WITH_CARRY_REG_PAT
               || op[7:1] == opcode_decode_pkg::ADD_WITH_CARRY_IND_PAT
               || op == opcode_decode_pkg::ADD_WITH_CARRY_DIR_OP
               || op == opcode_decode_pkg::ADD_WITH_CARRY_IMM_OP;
    endfunction

    add_unit u_add (
        .a_i   (cur_reg.acc),
        .b_i   (add_b),
        .cin_i (add_cin),
        .res_o (add_res)
    );

    always_comb begin
        add_b   = cur_reg.opnd;
        add_cin = is_add_with_carry(cur_reg.op) ? cur_reg.flg.cy : 1'b0;
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        logic [PC_W-1:0] ret;
        ret = '0;
        cur_next = cur_reg;
        cur_next.ram.we = 1'b0;
        cur_next.xwe = 1'b0;
        case (cur_reg.st)
            opcode_decode_pkg::ST_FETCH: begin
                cur_next.op = code_data_i;
                cur_next.pc = cur_reg.pc + PC_W'(1);
                if (is_call(code_data_i) || code_data_i == opcode_decode_pkg::CNT_DIR_OP
                    || code_data_i == opcode_decode_pkg::ADD_DIR_OP
                    || code_data_i == opcode_decode_pkg::ADD_IMM_OP
                    || code_data_i == opcode_decode_pkg::ADD_WITH_CARRY_DIR_OP
                    || code_data_i == opcode_decode_pkg::ADD_WITH_CARRY_IMM_OP
                    || code_data_i[7:3] == opcode_decode_pkg::CNT_REG_PAT) begin
                    cur_next.st = opcode_decode_pkg::ST_BYTE2;
                end else if (code_data_i == opcode_decode_pkg::XRD_DATA_POINTER_OP) begin
                    cur_next.xaddr = data_pointer_i;
                    cur_next.st = opcode_decode_pkg::ST_XREAD;
                end else if (code_data_i == opcode_decode_pkg::XWR_DATA_POINTER_OP) begin
                    cur_next.xaddr = data_pointer_i;
                    cur_next.xwd = cur_reg.acc;
                    cur_next.xwe = 1'b1;
                end else if (code_data_i == opcode_decode_pkg::CLR_ACC_OP) begin
                    cur_next.acc = 8'h00;
                end else if (code_data_i == opcode_decode_pkg::CPL_ACC_OP) begin
                    cur_next.acc = ~cur_reg.acc;
                end else if (code_data_i == opcode_decode_pkg::BIT_SET_C_OP) begin
                    cur_next.flg.cy = 1'b1;
                end else if (code_data_i[7:3] == opcode_decode_pkg::MOV_REG_A_PAT) begin
                    cur_next.ram = '{1'b1, reg_addr(bank_sel_i, code_data_i[2:0]), cur_reg.acc};
                end else if (code_data_i[7:1] == opcode_decode_pkg::ADD_IND_PAT
                             || code_data_i[7:1] == opcode_decode_pkg::ADD_WITH_CARRY_IND_PAT) begin
                    cur_next.ram.addr = reg_addr(bank_sel_i, {2'b00, code_data_i[0]});
                    cur_next.st = opcode_decode_pkg::ST_PTR;
                end else if (is_add(code_data_i) || is_add_with_carry(code_data_i)
                             || code_data_i[7:3] == opcode_decode_pkg::MOV_A_REG_PAT) begin
                    cur_next.ram.addr = reg_addr(bank_sel_i, code_data_i[2:0]);
                    cur_next.st = opcode_decode_pkg::ST_OPND;
                end
            end
            opcode_decode_pkg::ST_BYTE2: begin
                cur_next.b2 = code_data_i;
                cur_next.pc = cur_reg.pc + PC_W'(1);
                cur_next.st = opcode_decode_pkg::ST_FETCH;
                if (is_call(cur_reg.op)) begin
                    // Return address is the PC incremented once more, past the second byte
                    ret = cur_reg.pc + PC_W'(1);
                    cur_next.sp = cur_reg.sp + 8'h01;
                    cur_next.ram = '{1'b1, cur_reg.sp + 8'h01, ret[7:0]};
                    cur_next.st = opcode_decode_pkg::ST_PUSH_HI;
                end else if (cur_reg.op == opcode_decode_pkg::ADD_IMM_OP
                             || cur_reg.op == opcode_decode_pkg::ADD_WITH_CARRY_IMM_OP) begin
                    cur_next.opnd = code_data_i;
                    cur_next.st = opcode_decode_pkg::ST_PUSH_LO;
                end else if (cur_reg.op == opcode_decode_pkg::CNT_DIR_OP) begin
                    cur_next.ram.addr = code_data_i;
                    cur_next.st = opcode_decode_pkg::ST_BYTE3;
                end else if (cur_reg.op[7:3] == opcode_decode_pkg::CNT_REG_PAT) begin
                    cur_next.ram.addr = reg_addr(bank_sel_i, cur_reg.op[2:0]);
                    cur_next.st = opcode_decode_pkg::ST_CNT_WR;
                end else begin
                    cur_next.ram.addr = code_data_i;
                    cur_next.st = opcode_decode_pkg::ST_OPND;
                end
            end
            opcode_decode_pkg::ST_BYTE3: begin
                // Three-byte branch: offset byte taken here
                cur_next.b2 = code_data_i;
                cur_next.pc = cur_reg.pc + PC_W'(1);
                cur_next.st = opcode_decode_pkg::ST_CNT_WR;
            end
            opcode_decode_pkg::ST_CNT_WR: begin
                cur_next.ram.we = 1'b1;
                cur_next.ram.wdata = ram_rdata_i - 8'h01;
                if (ram_rdata_i != 8'h01) begin
                    cur_next.pc = cur_reg.pc + PC_W'({{8{cur_reg.b2[7]}}, cur_reg.b2});
                end
                cur_next.st = opcode_decode_pkg::ST_FETCH;
            end
            opcode_decode_pkg::ST_PTR: begin
                cur_next.ram.addr = ram_rdata_i;
                cur_next.st = opcode_decode_pkg::ST_OPND;
            end
            opcode_decode_pkg::ST_OPND: begin
                cur_next.opnd = ram_rdata_i;
                if (cur_reg.op[7:3] == opcode_decode_pkg::MOV_A_REG_PAT) begin
                    cur_next.acc = ram_rdata_i;
                    cur_next.st = opcode_decode_pkg::ST_FETCH;
                end else begin
                    cur_next.st = opcode_decode_pkg::ST_PUSH_LO;
                end
            end
            opcode_decode_pkg::ST_PUSH_LO: begin
                // Reused as the add write-back step
                cur_next.acc = add_res.sum;
                cur_next.flg = add_res.flg;
                cur_next.st = opcode_decode_pkg::ST_FETCH;
            end
            opcode_decode_pkg::ST_PUSH_HI: begin
                cur_next.sp = cur_reg.sp + 8'h01;
                cur_next.ram = '{1'b1, cur_reg.sp + 8'h01, 8'(cur_reg.pc >> 8)};
                // Top five bits kept, so no leaving the 2K block
                cur_next.pc = {cur_reg.pc[PC_W-1:opcode_decode_pkg::PAGE_LSB],
                               cur_reg.op[7:opcode_decode_pkg::OP_PAGE_LSB],
                               cur_reg.b2};
                // Flags untouched on this path
                cur_next.flg = cur_reg.flg;
                cur_next.st = opcode_decode_pkg::ST_FETCH;
            end
            opcode_decode_pkg::ST_XREAD: begin
                cur_next.acc = xram_rdata_i;
                cur_next.st = opcode_decode_pkg::ST_FETCH;
            end
            default: cur_next.st = opcode_decode_pkg::ST_FETCH;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur_reg <= '0;
            cur_reg.sp <= opcode_decode_pkg::SP_RESET;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign code_addr_o       = cur_reg.pc;
    assign program_counter_o = cur_reg.pc;
    assign ram_req_o         = cur_reg.ram;
    assign xram_addr_o       = cur_reg.xaddr;
    assign xram_wdata_o      = cur_reg.xwd;
    assign xram_we_o         = cur_reg.xwe;
    assign acc_o             = cur_reg.acc;
    assign stack_pointer_o   = cur_reg.sp;
    assign flags_o           = cur_reg.flg;
endmodule

// ==== opcode_decode_checker_assertions.sv ====
// Concurrent checks on the call, stack-pointer and external-write ports of the decoder.
// Assumes one core clock, an active-high async reset and PC_W of 16.
`timescale 1ns/1ps
module opcode_decode_checker #(
    parameter int PC_W = 16
) (
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_i,
    input  wire logic [7:0]              code_data_i,
    input  wire logic [15:0]             data_pointer_i,
    input  opcode_decode_pkg::ram_req_t  ram_req_o,
    input  wire logic [15:0]             xram_addr_o,
    input  wire logic [7:0]              xram_wdata_o,
    input  wire logic                    xram_we_o,
    input  wire logic [7:0]              acc_o,
    input  wire logic [7:0]              stack_pointer_o,
    input  opcode_decode_pkg::flags_t    flags_o,
    input  wire logic [PC_W-1:0]         program_counter_o
);
    // ************************************************************
    // Fetched byte history, opcode sits three samples back
    // ************************************************************
    logic [7:0] code_d1_reg;
    logic [7:0] code_d2_reg;
    logic [7:0] code_d3_reg;
    always_ff @(posedge sys_clk_i) begin
        code_d1_reg <= code_data_i;
        code_d2_reg <= code_d1_reg;
        code_d3_reg <= code_d2_reg;
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Low push only after a quiet stack pointer, so the high push is not mistaken for it
    sequence s_push_hi;
        ram_req_o.we && ram_req_o.addr == stack_pointer_o
            && stack_pointer_o == $past(stack_pointer_o) + 8'h01;
    endsequence
    sequence s_push_lo;
        s_push_hi ##0 $past(stack_pointer_o) == $past(stack_pointer_o, 2);
    endsequence

    property p_sp_step;
        $changed(stack_pointer_o) |-> stack_pointer_o == $past(stack_pointer_o) + 8'h01;
    endproperty
    a_sp_step: assert property (p_sp_step) else $error("stack pointer moved by other than one");
    property p_push_pair;
        s_push_lo |=> s_push_hi;
    endproperty
    a_push_pair: assert property (p_push_pair) else $error("second push missing");
    property p_push_data;
        s_push_lo |-> ram_req_o.wdata == program_counter_o[7:0]
            ##1 ram_req_o.wdata == $past(program_counter_o[15:8]);
    endproperty
    a_push_data: assert property (p_push_data) else $error("return bytes pushed wrongly");
    property p_call_target;
        s_push_lo ##1 s_push_hi |-> program_counter_o ==
            {$past(program_counter_o[15:11]), code_d3_reg[7:5], code_d2_reg};
    endproperty
    a_call_target: assert property (p_call_target) else $error("call target wrong");
    property p_call_opcode;
        s_push_lo ##1 s_push_hi |-> code_d3_reg[4:0] == 5'h11;
    endproperty
    a_call_opcode: assert property (p_call_opcode) else $error("push without call opcode");
    property p_call_block;
        s_push_lo |=> program_counter_o[15:11] == $past(program_counter_o[15:11]);
    endproperty
    a_call_block: assert property (p_call_block) else $error("call left its 2K block");
    property p_call_flags;
        s_push_lo |-> $stable(flags_o) && $stable(acc_o) ##1 $stable(flags_o);
    endproperty
    a_call_flags: assert property (p_call_flags) else $error("flags changed by call");
    property p_xwrite;
        xram_we_o |-> xram_addr_o == data_pointer_i && xram_wdata_o == acc_o;
    endproperty
    a_xwrite: assert property (p_xwrite) else $error("external write address or data wrong");
endmodule
bind opcode_decode_add_call opcode_decode_checker #(.PC_W(PC_W)) opcode_decode_checker_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .code_data_i(code_data_i),
    .data_pointer_i(data_pointer_i), .ram_req_o(ram_req_o), .xram_addr_o(xram_addr_o),
    .xram_wdata_o(xram_wdata_o), .xram_we_o(xram_we_o), .acc_o(acc_o),
    .stack_pointer_o(stack_pointer_o), .flags_o(flags_o),
    .program_counter_o(program_counter_o));

// ==== code_ram_model.sv ====
// Program memory, internal RAM and a small external RAM for the decoder.
// Assumes same-cycle reads; contents preset by the bench.
`timescale 1ns/1ps
module code_ram_model (
    input  wire logic                         sys_clk_i,
    input  wire logic [15:0]                  code_addr_i,
    output logic      [7:0]                   code_data_o,
    input  wire opcode_decode_pkg::ram_req_t  ram_req_i,
    output logic      [7:0]                   ram_rdata_o,
    input  wire logic [15:0]                  xram_addr_i,
    input  wire logic [7:0]                   xram_wdata_i,
    input  wire logic                         xram_we_i,
    output logic      [7:0]                   xram_rdata_o
);
    // ************************************************************
    // Storage, 4K of code only: higher fetches wrap
    // ************************************************************
    logic [7:0] code_mem [0:4095];
    logic [7:0] ram_mem  [0:255];
    logic [7:0] xram_mem [0:255];
    assign code_data_o  = code_mem[code_addr_i[11:0]];
    assign ram_rdata_o  = ram_mem[ram_req_i.addr];
    assign xram_rdata_o = xram_mem[xram_addr_i[7:0]];
    always @(posedge sys_clk_i) begin
        if (ram_req_i.we === 1'b1) ram_mem[ram_req_i.addr] <= ram_req_i.wdata;
        if (xram_we_i === 1'b1) xram_mem[xram_addr_i[7:0]] <= xram_wdata_i;
    end
endmodule

// ==== tb.sv ====
// Self-checking bench: runs a small program and compares results.
// Assumes the decoder and memory model above; 10 MHz core clock.
`timescale 1ns/1ps
module tb;
    logic                          sys_clk_i;
    logic                          rst_i;
    logic [1:0]                    bank_sel_i;
    logic [15:0]                   data_pointer_i;
    logic [7:0]                    code_data, ram_rdata, xram_rdata, xram_wdata, acc, sp;
    logic [15:0]                   code_addr, xram_addr, pc;
    logic                          xram_we;
    opcode_decode_pkg::ram_req_t   ram_req;
    opcode_decode_pkg::flags_t     flags;
    int                            mismatches, tests_run, cycles;
    // ************************************************************
    // Program {addr, byte} and checkpoints {pc, acc, cy ac ov}
    // ************************************************************
    localparam logic [23:0] PROG [32] = '{24'h000024, 24'h0001C3, 24'h000628, 24'h000B38,
        24'h001027, 24'h001525, 24'h001620, 24'h001BD3, 24'h001C35, 24'h001D20, 24'h002234,
        24'h00237F, 24'h0028F0, 24'h0029E4, 24'h002AE0, 24'h002F71, 24'h003045, 24'h0349F1,
        24'h034AFC, 24'h07FE11, 24'h07FF00, 24'h0803F4, 24'h0804FA, 24'h0805E4,
        // Tail: register moves, pointer add with carry, two count-down forms
        24'h0806EA, 24'h080737, 24'h080ADB, 24'h080BFE, 24'h080CD5, 24'h080D20,
        24'h080E03, 24'h080FE4};
    localparam logic [26:0] EXP [12] = '{{16'h0005, 8'hC3, 3'h0}, {16'h000A, 8'h6D, 3'h5},
        {16'h000F, 8'h18, 3'h6}, {16'h0014, 8'h80, 3'h3}, {16'h001A, 8'hE8, 3'h0},
        {16'h0021, 8'h51, 3'h6}, {16'h0027, 8'hD1, 3'h3}, {16'h002E, 8'hD1, 3'h3},
        {16'h0348, 8'hD1, 3'h3}, {16'h0803, 8'hD1, 3'h3}, {16'h080A, 8'h96, 3'h3},
        {16'h0813, 8'h96, 3'h3}};
    localparam logic [7:0] STACK [6] = '{8'h31, 8'h00, 8'h4B, 8'h03, 8'h00, 8'h08};

    opcode_decode_add_call #(.PC_W(16)) opcode_decode_add_call_i (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .code_data_i(code_data), .code_addr_o(code_addr),
        .ram_rdata_i(ram_rdata), .ram_req_o(ram_req), .bank_sel_i(bank_sel_i),
        .data_pointer_i(data_pointer_i), .xram_rdata_i(xram_rdata), .xram_addr_o(xram_addr),
        .xram_wdata_o(xram_wdata), .xram_we_o(xram_we), .acc_o(acc), .stack_pointer_o(sp),
        .flags_o(flags), .program_counter_o(pc));
    code_ram_model code_ram_model_i (
        .sys_clk_i(sys_clk_i), .code_addr_i(code_addr), .code_data_o(code_data),
        .ram_req_i(ram_req), .ram_rdata_o(ram_rdata), .xram_addr_i(xram_addr),
        .xram_wdata_i(xram_wdata), .xram_we_i(xram_we), .xram_rdata_o(xram_rdata));

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Bounded wait, sampled on the falling edge away from updates
    task automatic wait_pc(input logic [15:0] addr);
        int n;
        n = 0;
        while (pc !== addr && n < 300) begin
            @(negedge sys_clk_i);
            n++;
        end
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial begin
        mismatches = 0;
        tests_run = 0;
        cycles = 0;
        rst_i <= 1'b1;
        bank_sel_i <= 2'h2;
        data_pointer_i <= 16'h0055;
        for (int k = 0; k < 4096; k++) code_ram_model_i.code_mem[k] = 8'h00;
        for (int k = 0; k < 256; k++) code_ram_model_i.ram_mem[k] = 8'h00;
        foreach (PROG[k]) code_ram_model_i.code_mem[PROG[k][19:8]] = PROG[k][7:0];
        code_ram_model_i.ram_mem[8'h10] = 8'hAA;
        code_ram_model_i.ram_mem[8'h11] = 8'h20;
        code_ram_model_i.ram_mem[8'h20] = 8'h68;
        code_ram_model_i.ram_mem[8'h13] = 8'h02;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        foreach (EXP[k]) begin
            wait_pc(EXP[k][26:11]);
            chk("pc", EXP[k][26:11], pc);
            chk("acc", {8'h00, EXP[k][10:3]}, {8'h00, acc});
            chk("flags", {13'h0, EXP[k][2:0]}, {13'h0, flags});
        end
        chk("sp", 16'h000D, {8'h00, sp});
        foreach (STACK[k]) chk("stack", {8'h00, STACK[k]},
            {8'h00, code_ram_model_i.ram_mem[8'h08 + k]});
        chk("xram", 16'h00D1, {8'h00, code_ram_model_i.xram_mem[8'h55]});
        chk("reg2", 16'h002E, {8'h00, code_ram_model_i.ram_mem[8'h12]});
        chk("reg3", 16'h0000, {8'h00, code_ram_model_i.ram_mem[8'h13]});
        chk("direct", 16'h0067, {8'h00, code_ram_model_i.ram_mem[8'h20]});
        tally_and_finish();
    end
endmodule
